// ===== hw/pte_unit.sv
`timescale 1ns/1ps
module pte_unit
    import pte_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // Avalon-MM register slave
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    // Pads
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe,
    // General I/O block
    input  wire logic [NUM_PINS-1:0] gpio_out,
    input  wire logic [NUM_PINS-1:0] gpio_dir,
    input  wire logic                match_detect,
    input  wire logic                latched_match_mode,
    input  wire logic                latch_clear,
    // Event interconnect
    input  wire logic [NUM_CH-1:0]   ic_out_task,
    input  wire logic [NUM_CH-1:0]   ic_set_task,
    input  wire logic [NUM_CH-1:0]   ic_clr_task,
    output logic      [NUM_CH-1:0]   in_event,
    output logic                     port_event,
    // Power control
    input  wire logic                sysoff_req,
    output logic                     wake_reset
);

    // Bus handshake state
    logic                waitrequest_q;
    logic                waitrequest_d;
    logic [DATA_W-1:0]   readdata_q;
    logic [DATA_W-1:0]   readdata_d;

    // Channel state
    logic [DATA_W-1:0]   cfg_q [NUM_CH];
    logic [NUM_CH-1:0]   lvl_q;
    logic [NUM_CH-1:0]   lvl_d;
    logic [NUM_CH-1:0]   evt_flag_q;
    logic [NUM_CH-1:0]   evt_flag_d;
    logic [NUM_CH-1:0]   in_event_q;
    logic [NUM_CH-1:0]   evt_hit;

    // Port state
    logic                port_flag_q;
    logic                port_flag_d;
    logic                port_event_q;
    logic                port_hit;
    logic                wake_reset_q;

    // Pin drive
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_out_d;
    logic [NUM_PINS-1:0] pin_oe_q;
    logic [NUM_PINS-1:0] pin_oe_d;

    // Synchronised inputs
    logic [SYNC_W-1:0]   sync_level;
    logic [SYNC_W-1:0]   sync_rise;
    logic [SYNC_W-1:0]   sync_fall;

    pte_sync_edge u_sync (
        .clk    (clk),
        .rst_b  (rst_b),
        .raw_in ({match_detect, pin_in}),
        .level  (sync_level),
        .rise   (sync_rise),
        .fall   (sync_fall)
    );

    // Bus access decode
    wire                 rd_setup  = avs_read & waitrequest_q;
    wire                 wr_accept = avs_write & ~waitrequest_q;
    wire                 wr_zero   = (avs_writedata == '0);
    wire                 wr_trig   = avs_writedata[TASK_TRIG_BIT];
    wire                 hit_out   = bank_hit(avs_address, OFS_TASK_OUT);
    wire                 hit_set   = bank_hit(avs_address, OFS_TASK_SET);
    wire                 hit_clr   = bank_hit(avs_address, OFS_TASK_CLR);
    wire                 hit_evt   = bank_hit(avs_address, OFS_EVT_IN);
    wire                 hit_cfg   = bank_hit(avs_address, OFS_CONFIG);
    wire                 hit_port  = (avs_address[ADDR_W-1:WORD_LSB] ==
                                      OFS_EVT_PORT[ADDR_W-1:WORD_LSB]);
    wire                 hit_stat  = (avs_address[ADDR_W-1:WORD_LSB] ==
                                      OFS_STATUS[ADDR_W-1:WORD_LSB]);
    wire [CH_W-1:0]      ch_out    = bank_ch(avs_address, OFS_TASK_OUT);
    wire [CH_W-1:0]      ch_set    = bank_ch(avs_address, OFS_TASK_SET);
    wire [CH_W-1:0]      ch_clr    = bank_ch(avs_address, OFS_TASK_CLR);
    wire [CH_W-1:0]      ch_evt    = bank_ch(avs_address, OFS_EVT_IN);
    wire [CH_W-1:0]      ch_cfg    = bank_ch(avs_address, OFS_CONFIG);

    // One-cycle wait then accept
    assign waitrequest_d = ~((avs_read | avs_write) & waitrequest_q);

    // Next channel output level
    function automatic logic next_level(
        input logic        cur,
        input logic        cfg_wr,
        input logic [DATA_W-1:0] new_cfg,
        input logic [DATA_W-1:0] cfg,
        input logic        t_out,
        input logic        t_set,
        input logic        t_clr
    );
        logic nxt;
        nxt = cur;
        if (cfg_wr && cfg_mode(new_cfg) == MODE_TASK) begin
            nxt = new_cfg[CFG_INIT_BIT];
        end else if (cfg_mode(cfg) == MODE_TASK) begin
            if (t_out) begin
                unique case (cfg_pol(cfg))
                    POL_LOTOHI: nxt = 1'b1;
                    POL_HITOLO: nxt = 1'b0;
                    POL_TOGGLE: nxt = ~cur;
                    POL_NONE:   nxt = cur;
                endcase
            end else if (t_clr) begin
                nxt = 1'b0;
            end else if (t_set) begin
                nxt = 1'b1;
            end
        end
        return nxt;
    endfunction : next_level

    // Edge match for an event-mode channel
    function automatic logic edge_match(
        input logic [DATA_W-1:0] cfg,
        input logic              rise,
        input logic              fall
    );
        logic hit;
        hit = 1'b0;
        if (cfg_mode(cfg) == MODE_EVENT) begin
            unique case (cfg_pol(cfg))
                POL_LOTOHI: hit = rise;
                POL_HITOLO: hit = fall;
                POL_TOGGLE: hit = rise | fall;
                POL_NONE:   hit = 1'b0;
            endcase
        end
        return hit;
    endfunction : edge_match

    // Per-channel tasks, levels and events
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        wire [CH_W-1:0]  idx     = CH_W'(i);
        wire [PIN_W-1:0] psel    = cfg_psel(cfg_q[i]);
        wire             sw_out  = wr_accept & hit_out & wr_trig & (ch_out == idx);
        wire             sw_set  = wr_accept & hit_set & wr_trig & (ch_set == idx);
        wire             sw_clr  = wr_accept & hit_clr & wr_trig & (ch_clr == idx);
        wire             cfg_wr  = wr_accept & hit_cfg & (ch_cfg == idx);
        wire             evt_clr = wr_accept & hit_evt & wr_zero & (ch_evt == idx);
        wire [DATA_W-1:0] new_cfg = avs_writedata & CFG_WMASK;

        // Interconnect tasks share the register tasks
        wire             t_out   = sw_out | ic_out_task[i];
        wire             t_set   = sw_set | ic_set_task[i];
        wire             t_clr   = sw_clr | ic_clr_task[i];

        assign lvl_d[i] = next_level(lvl_q[i], cfg_wr, new_cfg, cfg_q[i],
                                     t_out, t_set, t_clr);
        assign evt_hit[i] = edge_match(cfg_q[i], sync_rise[psel], sync_fall[psel]);
        assign evt_flag_d[i] = evt_hit[i] | (evt_flag_q[i] & ~evt_clr);

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                cfg_q[i] <= CFG_RESET;
            end else if (cfg_wr) begin
                cfg_q[i] <= new_cfg;
            end
        end
    end

    // Port event from combined match signal
    wire port_clr = wr_accept & hit_port & wr_zero;
    wire det_lvl  = sync_level[NUM_PINS];
    wire det_rise = sync_rise[NUM_PINS];
    wire rearm    = latched_match_mode & latch_clear & det_lvl;

    // No clock or power request is raised for this path
    assign port_hit    = det_rise | rearm;
    assign port_flag_d = port_hit | (port_flag_q & ~port_clr);

    // Pin ownership and drive
    always_comb begin
        pin_out_d = gpio_out;
        pin_oe_d  = gpio_dir;
        for (int p = 0; p < NUM_PINS; p++) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (cfg_psel(cfg_q[c]) == PIN_W'(p)) begin
                    if (cfg_mode(cfg_q[c]) == MODE_TASK) begin
                        pin_out_d[p] = lvl_q[c];
                        pin_oe_d[p]  = 1'b1;
                    end else if (cfg_mode(cfg_q[c]) == MODE_EVENT) begin
                        pin_oe_d[p]  = 1'b0;
                    end
                end
            end
        end
    end

    // Read data select
    always_comb begin
        readdata_d = readdata_q;
        if (rd_setup) begin
            readdata_d = '0;
            if (hit_cfg) begin
                readdata_d = cfg_q[ch_cfg];
            end else if (hit_evt) begin
                readdata_d = DATA_W'(evt_flag_q[ch_evt]);
            end else if (hit_port) begin
                readdata_d = DATA_W'(port_flag_q);
            end else if (hit_stat) begin
                readdata_d = DATA_W'(lvl_q);
                readdata_d[STAT_DET_BIT] = det_lvl;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest_q <= 1'b1;
            readdata_q    <= '0;
        end else begin
            waitrequest_q <= waitrequest_d;
            readdata_q    <= readdata_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_q        <= '0;
            evt_flag_q   <= '0;
            in_event_q   <= '0;
            port_flag_q  <= 1'b0;
            port_event_q <= 1'b0;
        end else begin
            lvl_q        <= lvl_d;
            evt_flag_q   <= evt_flag_d;
            in_event_q   <= evt_hit;
            port_flag_q  <= port_flag_d;
            port_event_q <= port_hit;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_q    <= '0;
            pin_oe_q     <= '0;
            wake_reset_q <= 1'b0;
        end else begin
            pin_out_q    <= pin_out_d;
            pin_oe_q     <= pin_oe_d;
            wake_reset_q <= sysoff_req & det_lvl;
        end
    end

    assign avs_readdata    = readdata_q;
    assign avs_waitrequest = waitrequest_q;
    assign pin_out         = pin_out_q;
    assign pin_oe          = pin_oe_q;
    assign in_event        = in_event_q;
    assign port_event      = port_event_q;
    assign wake_reset      = wake_reset_q;

endmodule : pte_unit

// ===== shared/pte_pkg.sv
// What this block does
// - Eight independent channels, each with tasks, an input event and a configuration.
// - Each channel binds to exactly one pin chosen by its pin-select field.
// - Three write tasks per channel: drive high, drive low, configurable output.
// - Input event raised on rising edge, falling edge or any change, as configured.
// - Drive-high task forces the selected pin high.
// - Drive-low task forces the selected pin low.
// - Output task sets, clears or inverts the pin per action-polarity field.
// - All tasks and the event of a channel use its single configuration register.
// - A controlled pin takes its output only from this unit; general I/O ignored.
// - A disconnected channel returns the pin to general I/O values.
// - Same-cycle tasks: output beats drive-low, drive-low beats drive-high.
// - Task mode with no-action polarity: colliding output task leaves pin unchanged.
// - Entering task mode drives the pin to the initial-output field level.
// - Port event on each rising edge of the combined pin-match signal.
// - Latched matching with a latch bit still high after clear gives a new event.
// - Power-off request while match is high causes an immediate wakeup reset.
// - Port detection needs no clock or power request and can wake the processor.
// - Channel events drive the interconnect; interconnect events trigger pin tasks.
// - Event mode makes pin input; task mode makes it output; disabled keeps own setup.
package pte_pkg;

    localparam int unsigned NUM_CH   = 8;
    localparam int unsigned NUM_PINS = 32;
    localparam int unsigned SYNC_W   = NUM_PINS + 1;
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CH_W     = 3;
    localparam int unsigned PIN_W    = 5;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TASK_OUT = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_TASK_SET = 12'h030;
    localparam logic [ADDR_W-1:0] OFS_TASK_CLR = 12'h060;
    localparam logic [ADDR_W-1:0] OFS_EVT_IN   = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_EVT_PORT = 12'h17c;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h400;
    localparam logic [ADDR_W-1:0] OFS_CONFIG   = 12'h510;
    localparam logic [ADDR_W-1:0] BANK_SPAN    = 12'h020;
    localparam int unsigned       WORD_LSB     = 2;

    // Configuration fields
    localparam int unsigned       CFG_MODE_LSB = 0;
    localparam int unsigned       CFG_PSEL_LSB = 8;
    localparam int unsigned       CFG_POL_LSB  = 16;
    localparam int unsigned       CFG_INIT_BIT = 20;
    localparam logic [DATA_W-1:0] CFG_WMASK    = 32'h0013_1f03;
    localparam logic [DATA_W-1:0] CFG_RESET    = 32'h0000_0000;
    localparam int unsigned       TASK_TRIG_BIT = 0;
    localparam int unsigned       STAT_DET_BIT  = 8;

    typedef enum logic [1:0] {
        MODE_DISABLED = 2'h0,
        MODE_EVENT    = 2'h1,
        MODE_RSVD     = 2'h2,
        MODE_TASK     = 2'h3
    } pte_mode_t;

    typedef enum logic [1:0] {
        POL_NONE   = 2'h0,
        POL_LOTOHI = 2'h1,
        POL_HITOLO = 2'h2,
        POL_TOGGLE = 2'h3
    } pte_pol_t;

    function automatic pte_mode_t cfg_mode(input logic [DATA_W-1:0] cfg);
        return pte_mode_t'(cfg[CFG_MODE_LSB +: 2]);
    endfunction : cfg_mode

    function automatic pte_pol_t cfg_pol(input logic [DATA_W-1:0] cfg);
        return pte_pol_t'(cfg[CFG_POL_LSB +: 2]);
    endfunction : cfg_pol

    function automatic logic [PIN_W-1:0] cfg_psel(input logic [DATA_W-1:0] cfg);
        return cfg[CFG_PSEL_LSB +: PIN_W];
    endfunction : cfg_psel

    // Address lies in an eight-word bank starting at base
    function automatic logic bank_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        return (addr >= base) && (diff < BANK_SPAN);
    endfunction : bank_hit

    function automatic logic [CH_W-1:0] bank_ch(input logic [ADDR_W-1:0] addr,
                                                input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        return diff[WORD_LSB +: CH_W];
    endfunction : bank_ch

endpackage : pte_pkg

// ===== hw/pte_sync_edge.sv
`timescale 1ns/1ps
module pte_sync_edge
    import pte_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Raw levels
    input  wire logic [SYNC_W-1:0] raw_in,
    // Synchronised levels and edges
    output logic      [SYNC_W-1:0] level,
    output logic      [SYNC_W-1:0] rise,
    output logic      [SYNC_W-1:0] fall
);

    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule : pte_sync_edge

// ===== sim/pte_unit_monitor.sv
`timescale 1ns/1ps
module pte_unit_monitor
    import pte_pkg::*;
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // Register bus
    input wire logic [ADDR_W-1:0]   avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [DATA_W-1:0]   avs_readdata,
    input wire logic                avs_waitrequest,
    // Pins and events
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic                match_detect,
    input wire logic                sysoff_req,
    input wire logic [NUM_CH-1:0]   in_event,
    input wire logic                port_event,
    input wire logic                wake_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without request");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[11]
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_port_rise: assert property ($rose(match_detect) |-> ##[1:6] port_event)
        else $error("no port event after match rise");
    a_wake_match: assert property ((sysoff_req && match_detect) [*5] |=> wake_reset)
        else $error("no wake on power-off with match");
    a_wake_idle: assert property (!sysoff_req |=> !wake_reset)
        else $error("wake without power-off request");
    a_event_cause: assert property (|in_event |-> $past(pin_in, 3) != $past(pin_in, 4))
        else $error("input event without pin change");
endmodule : pte_unit_monitor

bind pte_unit pte_unit_monitor mon_u (
    .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .pin_in, .match_detect, .sysoff_req, .in_event, .port_event, .wake_reset
);

// ===== sim/pte_pad_model.sv
`timescale 1ns/1ps
module pte_pad_model
    import pte_pkg::*;
(
    // Unit side
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    // Board drivers
    input  wire logic [NUM_PINS-1:0] ext_val,
    input  wire logic [NUM_PINS-1:0] ext_en,
    // Pad level seen by the unit
    output logic      [NUM_PINS-1:0] pin_in
);
    // Pads nobody drives sit on a pull-down
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val);
endmodule : pte_pad_model

// ===== sim/pte_unit_tb_top.sv
`timescale 1ns/1ps
module pte_unit_tb_top;
    import pte_pkg::*;

    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic [ADDR_W-1:0]   avs_address = 12'h0;
    logic                avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [DATA_W-1:0]   avs_writedata = 32'h0, avs_readdata, rdata;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe;
    logic [NUM_PINS-1:0] gpio_out = 32'h1234_5470, gpio_dir = 32'hff00_ff00;
    logic [NUM_PINS-1:0] ext_val = 32'h0, ext_en = 32'h0;
    logic [NUM_CH-1:0]   ic_out = 8'h0, ic_set = 8'h0, ic_clr = 8'h0, in_event;
    logic                match_detect = 1'b0, lmode = 1'b0, lclr = 1'b0;
    logic                sysoff_req = 1'b0, port_event, wake_reset;
    int                  fail_count = 0, check_count = 0, ev_cnt = 0, pe_cnt = 0;

    always #25 clk = ~clk;

    always @(posedge clk) begin
        ev_cnt <= ev_cnt + int'(in_event[5]);
        pe_cnt <= pe_cnt + int'(port_event);
    end

    pte_unit dut_u (
        .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .gpio_out, .gpio_dir, .match_detect,
        .latched_match_mode(lmode), .latch_clear(lclr), .ic_out_task(ic_out),
        .ic_set_task(ic_set), .ic_clr_task(ic_clr), .in_event, .port_event, .sysoff_req,
        .wake_reset
    );

    pte_pad_model pad_u (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        // Request stands until the edge that samples waitrequest low
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic cfg(input int ch, input logic [1:0] m, input logic [4:0] p,
                       input logic [1:0] pol, input logic ini);
        bus(1'b1, OFS_CONFIG + 12'(4 * ch), {11'h0, ini, 2'h0, pol, 3'h0, p, 6'h0, m});
    endtask : cfg

    task automatic t_reset();
        settle(1);
        chk("pin_out", gpio_out, pin_out);
        chk("pin_oe", gpio_dir, pin_oe);
        bus(1'b0, OFS_CONFIG + 12'h01c, 32'h0);
        chk("cfg7", 32'h0, rdata);
        bus(1'b1, 12'h800, 32'hffff_ffff);
        bus(1'b0, 12'h800, 32'h0);
        chk("unmapped", 32'h0, rdata);
        bus(1'b1, OFS_CONFIG, 32'hffff_ffff);
        bus(1'b0, OFS_CONFIG, 32'h0);
        chk("cfg_rw", CFG_WMASK, rdata);
        bus(1'b1, OFS_CONFIG, 32'h0);
    endtask : t_reset

    task automatic t_task();
        logic [1:0] pol;
        logic       ini;
        cfg(2, 2'h3, 5'h04, 2'h0, 1'b1);
        settle(1);
        chk("init", 32'h3, 32'({pin_oe[4], pin_out[4]}));
        @(posedge clk);
        gpio_out <= gpio_out ^ 32'h10;
        settle(1);
        chk("gpio_ign", 32'h1, 32'(pin_out[4]));
        bus(1'b1, OFS_TASK_CLR + 12'h008, 32'h1);
        settle(1);
        chk("clr", 32'h0, 32'(pin_out[4]));
        bus(1'b1, OFS_TASK_SET + 12'h008, 32'h1);
        settle(1);
        chk("set", 32'h1, 32'(pin_out[4]));
        for (int i = 0; i < 8; i++) begin
            pol = 2'(i);
            ini = (i > 3);
            cfg(2, 2'h3, 5'h04, pol, ini);
            bus(1'b1, OFS_TASK_OUT + 12'h008, 32'h1);
            settle(1);
            chk("out", 32'((pol == 2'h0) ? ini : (pol == 2'h3) ? !ini : pol[0]),
                32'(pin_out[4]));
        end
        bus(1'b1, OFS_TASK_SET + 12'h008, 32'h2);
        settle(1);
        chk("set_bit0", 32'h0, 32'(pin_out[4]));
        cfg(2, 2'h0, 5'h04, 2'h0, 1'b0);
        bus(1'b1, OFS_TASK_SET + 12'h008, 32'h1);
        settle(1);
        chk("released", 32'({gpio_dir[4], gpio_out[4]}), 32'({pin_oe[4], pin_out[4]}));
    endtask : t_task

    task automatic t_prio();
        logic [6:0] tbl [5];
        tbl = '{7'h2f, 7'h5a, 7'h36, 7'h1d, 7'h0a};
        foreach (tbl[i]) begin
            cfg(3, 2'h3, 5'h04, tbl[i][6:5], tbl[i][4]);
            @(posedge clk);
            ic_out[3] <= tbl[i][3];
            ic_clr[3] <= tbl[i][2];
            ic_set[3] <= tbl[i][1];
            @(posedge clk);
            ic_out <= 8'h0;
            ic_clr <= 8'h0;
            ic_set <= 8'h0;
            settle(1);
            chk("prio", 32'(tbl[i][0]), 32'(pin_out[4]));
        end
        cfg(3, 2'h0, 5'h04, 2'h0, 1'b0);
    endtask : t_prio

    task automatic t_chans();
        // One channel per pin
        for (int c = 0; c < 8; c++) begin
            cfg(c, 2'h3, 5'(16 + c), 2'h0, 1'b0);
            bus(1'b1, OFS_TASK_SET + 12'(4 * c), 32'h1);
            settle(1);
            chk("chan", 32'h3, 32'({pin_oe[16 + c], pin_out[16 + c]}));
        end
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("levels", 32'hff, rdata);
        for (int c = 0; c < 8; c++) cfg(c, 2'h0, 5'(16 + c), 2'h0, 1'b0);
    endtask : t_chans

    task automatic t_event();
        int base;
        @(posedge clk);
        ext_en[9] <= 1'b1;
        for (int p = 1; p < 4; p++) begin
            cfg(5, 2'h1, 5'h09, 2'(p), 1'b0);
            settle(1);
            chk("ev_oe", 32'h0, 32'(pin_oe[9]));
            base = ev_cnt;
            @(posedge clk);
            ext_val[9] <= 1'b1;
            settle(8);
            chk("ev_rise", 32'(p != 2), 32'(ev_cnt - base));
            base = ev_cnt;
            @(posedge clk);
            ext_val[9] <= 1'b0;
            settle(8);
            chk("ev_fall", 32'(p != 1), 32'(ev_cnt - base));
        end
        bus(1'b0, OFS_EVT_IN + 12'h010, 32'h0);
        chk("ev_other", 32'h0, rdata);
        bus(1'b1, OFS_EVT_IN + 12'h014, 32'h2);
        bus(1'b0, OFS_EVT_IN + 12'h014, 32'h0);
        chk("ev_sticky", 32'h1, rdata);
        bus(1'b1, OFS_EVT_IN + 12'h014, 32'h0);
        bus(1'b0, OFS_EVT_IN + 12'h014, 32'h0);
        chk("ev_clear", 32'h0, rdata);
        cfg(5, 2'h0, 5'h09, 2'h0, 1'b0);
    endtask : t_event

    task automatic t_port();
        int base;
        bus(1'b1, OFS_EVT_PORT, 32'h0);
        base = pe_cnt;
        @(posedge clk);
        match_detect <= 1'b1;
        settle(8);
        chk("port", 32'h1, 32'(pe_cnt - base));
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("match_lvl", 32'h1, 32'(rdata[STAT_DET_BIT]));
        bus(1'b0, OFS_EVT_PORT, 32'h0);
        chk("port_flag", 32'h1, rdata);
        bus(1'b1, OFS_EVT_PORT, 32'h0);
        bus(1'b0, OFS_EVT_PORT, 32'h0);
        chk("port_clr", 32'h0, rdata);
        @(posedge clk);
        lmode <= 1'b1;
        lclr  <= 1'b1;
        @(posedge clk);
        lclr <= 1'b0;
        settle(6);
        chk("latch", 32'h2, 32'(pe_cnt - base));
        @(posedge clk);
        sysoff_req <= 1'b1;
        settle(8);
        chk("wake", 32'h1, 32'(wake_reset));
        @(posedge clk);
        match_detect <= 1'b0;
        lmode        <= 1'b0;
        settle(8);
        chk("no_wake", 32'h0, 32'(wake_reset));
        @(posedge clk);
        sysoff_req <= 1'b0;
    endtask : t_port

    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_task();
        t_prio();
        t_chans();
        t_event();
        t_port();
        report_and_stop();
    end

    initial begin
        #(20000 * 50);
        fail_count++;
        report_and_stop();
    end
endmodule : pte_unit_tb_top
